// [inc/burst4_pkg.sv]
/*
  Shared constants and types for the four-word burst SRAM port: burst
  shape, lane layout, pipeline positions and reset values.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package burst4_pkg;

  // Burst shape and lane layout.
  localparam int WORDS = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W_DEF = 18;
  localparam int ADDR_W_DEF = 8;

  // Cycles from a latched read to the first launched word pair.
  localparam int READ_LAT = 2;

  // Controller pipeline taps, counted in edges after the issuing edge.
  localparam int WR_TAPS = 2;
  localparam int RD_TAPS = 5;
  localparam int RD_LOW_TAP = 3;
  localparam int RD_HIGH_TAP = 4;
  localparam int RSP_DEPTH = 2;

  // Values after reset.
  localparam logic RST_SELECT_N = 1'b1;
  localparam logic RST_OE = 1'b0;
  localparam logic RST_RUN = 1'b0;

  typedef enum logic [1:0] {OP_NONE, OP_READ, OP_WRITE} op_t;

endpackage : burst4_pkg

// [inc/sram_port_if.sv]
/*
  Port between the memory controller and the burst SRAM device.
  Each CLK edge while run is high is one positive clock rise; the
  _rise and _fall buses carry the word pairs of the two clock rises of one cycle.
*/
`timescale 1ns/1ps
interface sram_port_if #(
  parameter int DATA_W = burst4_pkg::DATA_W_DEF,
  parameter int ADDR_W = burst4_pkg::ADDR_W_DEF
);
  localparam int LANES = DATA_W / burst4_pkg::LANE_W;

  logic run;
  logic read_port_select_n;
  logic write_port_select_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] d_rise;
  logic [DATA_W-1:0] d_fall;
  logic [LANES-1:0] byte_lane_write_select_n_rise;
  logic [LANES-1:0] byte_lane_write_select_n_fall;
  logic [DATA_W-1:0] q_rise;
  logic [DATA_W-1:0] q_fall;
  logic q_oe;

  modport dev (
    input run, read_port_select_n, write_port_select_n, addr,
    input d_rise, d_fall,
    input byte_lane_write_select_n_rise, byte_lane_write_select_n_fall,
    output q_rise, q_fall, q_oe
  );

  modport ctl (
    output run, read_port_select_n, write_port_select_n, addr,
    output d_rise, d_fall,
    output byte_lane_write_select_n_rise, byte_lane_write_select_n_fall,
    input q_rise, q_fall, q_oe
  );

endinterface : sram_port_if

// [logic/burst4_sram_controller.sv]
/*
  Controller end of the burst SRAM port: takes whole-burst commands,
  drives selects, address and write data, collects read bursts into a
  two-entry response buffer. Assumes the device shares CLK and RESETN.
*/
`timescale 1ns/1ps
module burst4_sram_controller #(
  parameter int DATA_W = burst4_pkg::DATA_W_DEF,
  parameter int ADDR_W = burst4_pkg::ADDR_W_DEF
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Command port
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic CMD_WRITE,
  input wire logic [ADDR_W-1:0] CMD_ADDR,
  input wire logic [burst4_pkg::WORDS*DATA_W-1:0] CMD_WDATA,
  input wire logic [burst4_pkg::WORDS*(DATA_W/burst4_pkg::LANE_W)-1:0]
    CMD_LANE_N,
  // Read response port
  output logic RSP_VALID,
  input wire logic RSP_READY,
  output logic [burst4_pkg::WORDS*DATA_W-1:0] RSP_DATA,
  // Port towards the device
  sram_port_if.ctl PORT
);
  import burst4_pkg::*;

  localparam int LANES = DATA_W / LANE_W;
  localparam int BW = WORDS * DATA_W;
  localparam int LW = WORDS * LANES;

  generate
    if (DATA_W != 18 && DATA_W != 36)
    begin : g_bad_width
      $error("DATA_W must be 18 or 36");
    end
  endgenerate

  function automatic logic [2:0] ones(input logic [RD_TAPS-1:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < RD_TAPS; i++)
    begin
      n = n + {2'h0, v[i]};
    end
    return n;
  endfunction : ones

  logic run_reg, run_next;
  logic rps_n_reg, rps_n_next;
  logic wps_n_reg, wps_n_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] d_rise_reg, d_rise_next;
  logic [DATA_W-1:0] d_fall_reg, d_fall_next;
  logic [LANES-1:0] bl_rise_reg, bl_rise_next;
  logic [LANES-1:0] bl_fall_reg, bl_fall_next;
  logic [BW-1:0] wdata_reg, wdata_next;
  logic [LW-1:0] lane_reg, lane_next;
  logic [WR_TAPS-1:0] wr_sh_reg, wr_sh_next;
  logic [RD_TAPS-1:0] rd_sh_reg, rd_sh_next;
  logic [2*DATA_W-1:0] rx_low_reg, rx_low_next;
  logic ready_reg, ready_next;
  logic head_v_reg, head_v_next;
  logic spare_v_reg, spare_v_next;
  logic [BW-1:0] head_reg, head_next;
  logic [BW-1:0] spare_reg, spare_next;
  logic accept;
  logic push;
  logic [2:0] held;

  always_comb
  begin
    accept = CMD_VALID && ready_reg;
    push = rd_sh_reg[RD_HIGH_TAP];
    wr_sh_next = {wr_sh_reg[WR_TAPS-2:0], accept && CMD_WRITE};
    rd_sh_next = {rd_sh_reg[RD_TAPS-2:0], accept && !CMD_WRITE};
    // one op per two cycles
    // Issuing at most every other edge keeps reads and writes from
    // ever repeating back to back, at half the peak command rate.
    rps_n_next = !(accept && !CMD_WRITE);
    wps_n_next = !(accept && CMD_WRITE);
    addr_next = accept ? CMD_ADDR : addr_reg;
    wdata_next = accept ? CMD_WDATA : wdata_reg;
    lane_next = accept ? CMD_LANE_N : lane_reg;
    d_rise_next = d_rise_reg;
    d_fall_next = d_fall_reg;
    bl_rise_next = {LANES{1'b1}};
    bl_fall_next = {LANES{1'b1}};
    if (wr_sh_reg[0])
    begin
      d_rise_next = wdata_reg[0 +: DATA_W];
      d_fall_next = wdata_reg[DATA_W +: DATA_W];
      bl_rise_next = lane_reg[0 +: LANES];
      bl_fall_next = lane_reg[LANES +: LANES];
    end
    else if (wr_sh_reg[1])
    begin
      d_rise_next = wdata_reg[2*DATA_W +: DATA_W];
      d_fall_next = wdata_reg[3*DATA_W +: DATA_W];
      bl_rise_next = lane_reg[2*LANES +: LANES];
      bl_fall_next = lane_reg[3*LANES +: LANES];
    end
    rx_low_next = rd_sh_reg[RD_LOW_TAP] ? {PORT.q_fall, PORT.q_rise} :
      rx_low_reg;
    // Response buffer: pop first, then push into the free slot.
    head_v_next = head_v_reg;
    spare_v_next = spare_v_reg;
    head_next = head_reg;
    spare_next = spare_reg;
    if (head_v_reg && RSP_READY)
    begin
      head_v_next = spare_v_reg;
      head_next = spare_reg;
      spare_v_next = 1'b0;
    end
    if (push)
    begin
      if (!head_v_next)
      begin
        head_v_next = 1'b1;
        head_next = {PORT.q_fall, PORT.q_rise, rx_low_reg};
      end
      else
      begin
        spare_v_next = 1'b1;
        spare_next = {PORT.q_fall, PORT.q_rise, rx_low_reg};
      end
    end
    // Reads in flight are counted against the buffer, so a stalled
    // receiver can never see a burst dropped.
    held = ones(rd_sh_next) + {2'h0, head_v_next} + {2'h0, spare_v_next};
    ready_next = !accept && held < 3'(RSP_DEPTH);
    // clocks stopped when idle
    // Clocks run only while a burst is in flight; stopped clocks stand
    // for clocks parked high. The device stores the last write pair one
    // edge after it is driven, so the clocks run through that edge too.
    run_next = accept || (|wr_sh_next) || (|rd_sh_next) ||
      wr_sh_reg[WR_TAPS-1];
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      run_reg <= RST_RUN;
      rps_n_reg <= RST_SELECT_N;
      wps_n_reg <= RST_SELECT_N;
      addr_reg <= '0;
      d_rise_reg <= '0;
      d_fall_reg <= '0;
      bl_rise_reg <= '1;
      bl_fall_reg <= '1;
      wdata_reg <= '0;
      lane_reg <= '1;
      wr_sh_reg <= '0;
      rd_sh_reg <= '0;
      rx_low_reg <= '0;
      ready_reg <= 1'b0;
      head_v_reg <= 1'b0;
      spare_v_reg <= 1'b0;
      head_reg <= '0;
      spare_reg <= '0;
    end
    else
    begin
      run_reg <= run_next;
      rps_n_reg <= rps_n_next;
      wps_n_reg <= wps_n_next;
      addr_reg <= addr_next;
      d_rise_reg <= d_rise_next;
      d_fall_reg <= d_fall_next;
      bl_rise_reg <= bl_rise_next;
      bl_fall_reg <= bl_fall_next;
      wdata_reg <= wdata_next;
      lane_reg <= lane_next;
      wr_sh_reg <= wr_sh_next;
      rd_sh_reg <= rd_sh_next;
      rx_low_reg <= rx_low_next;
      ready_reg <= ready_next;
      head_v_reg <= head_v_next;
      spare_v_reg <= spare_v_next;
      head_reg <= head_next;
      spare_reg <= spare_next;
    end
  end

  assign CMD_READY = ready_reg;
  assign RSP_VALID = head_v_reg;
  assign RSP_DATA = head_reg;
  assign PORT.run = run_reg;
  assign PORT.read_port_select_n = rps_n_reg;
  assign PORT.write_port_select_n = wps_n_reg;
  assign PORT.addr = addr_reg;
  assign PORT.d_rise = d_rise_reg;
  assign PORT.d_fall = d_fall_reg;
  assign PORT.byte_lane_write_select_n_rise = bl_rise_reg;
  assign PORT.byte_lane_write_select_n_fall = bl_fall_reg;

endmodule : burst4_sram_controller

// [logic/burst4_sram_device.sv]
/*
  Device end of the burst SRAM port: arbitration of the port selects,
  write capture with byte lane masking, the read pipeline and the array.
  Assumes the controller drives the interface from the same CLK and
  that run low stands for stopped input clocks.
*/
`timescale 1ns/1ps
module burst4_sram_device #(
  parameter int DATA_W = burst4_pkg::DATA_W_DEF,
  parameter int ADDR_W = burst4_pkg::ADDR_W_DEF
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Port towards the controller
  sram_port_if.dev PORT
);
  import burst4_pkg::*;

  localparam int LANES = DATA_W / LANE_W;
  localparam int DEPTH = 1 << ADDR_W;

  generate
    if (DATA_W != 18 && DATA_W != 36)
    begin : g_bad_width
      $error("DATA_W must be 18 or 36");
    end
  endgenerate

  // Burst storage; one entry holds the four words of one address.
  logic [DATA_W-1:0] mem [0:DEPTH-1][0:WORDS-1];

  op_t last_op_reg, last_op_next;
  logic wr1_reg, wr1_next;
  logic wr2_reg, wr2_next;
  logic [ADDR_W-1:0] waddr1_reg, waddr1_next;
  logic [ADDR_W-1:0] waddr2_reg, waddr2_next;
  logic rd1_reg, rd1_next;
  logic rd2_reg, rd2_next;
  logic rd3_reg, rd3_next;
  logic [ADDR_W-1:0] raddr1_reg, raddr1_next;
  logic [ADDR_W-1:0] raddr2_reg, raddr2_next;
  logic [ADDR_W-1:0] raddr3_reg, raddr3_next;
  logic [DATA_W-1:0] q_rise_reg, q_rise_next;
  logic [DATA_W-1:0] q_fall_reg, q_fall_next;
  logic q_oe_reg, q_oe_next;
  logic take_rd;
  logic take_wr;

  always_comb
  begin
    take_rd = 1'b0;
    take_wr = 1'b0;
    last_op_next = last_op_reg;
    wr1_next = wr1_reg;
    wr2_next = wr2_reg;
    waddr1_next = waddr1_reg;
    waddr2_next = waddr2_reg;
    rd1_next = rd1_reg;
    rd2_next = rd2_reg;
    rd3_next = rd3_reg;
    raddr1_next = raddr1_reg;
    raddr2_next = raddr2_reg;
    raddr3_next = raddr3_reg;
    q_rise_next = q_rise_reg;
    q_fall_next = q_fall_reg;
    q_oe_next = q_oe_reg;
    // stopped hold
    // Nothing moves while the clocks are stopped, so every output keeps
    // its previous level.
    if (PORT.run)
    begin
      // no repeats
      // A select that started the previous operation is ignored, which
      // also throws away a second request of the same type.
      take_rd = !PORT.read_port_select_n && last_op_reg != OP_READ;
      take_wr = !PORT.write_port_select_n && last_op_reg != OP_WRITE &&
        !take_rd;
      last_op_next = take_rd ? OP_READ : (take_wr ? OP_WRITE : OP_NONE);
      wr1_next = take_wr;
      waddr1_next = PORT.addr;
      wr2_next = wr1_reg;
      waddr2_next = waddr1_reg;
      rd1_next = take_rd;
      raddr1_next = PORT.addr;
      rd2_next = rd1_reg;
      raddr2_next = raddr1_reg;
      rd3_next = rd2_reg;
      raddr3_next = raddr2_reg;
      // read launch
      // Writes land in the array one and two edges after capture, so a read two cycles later
      // already sees them and no separate bypass path is needed.
      // newest data
      if (rd2_reg)
      begin
        q_rise_next = mem[raddr2_reg][0];
        q_fall_next = mem[raddr2_reg][1];
        q_oe_next = 1'b1;
      end
      else if (rd3_reg)
      begin
        q_rise_next = mem[raddr3_reg][2];
        q_fall_next = mem[raddr3_reg][3];
        q_oe_next = 1'b1;
      end
      else
      begin
        q_oe_next = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      last_op_reg <= OP_NONE;
      wr1_reg <= 1'b0;
      wr2_reg <= 1'b0;
      waddr1_reg <= '0;
      waddr2_reg <= '0;
      rd1_reg <= 1'b0;
      rd2_reg <= 1'b0;
      rd3_reg <= 1'b0;
      raddr1_reg <= '0;
      raddr2_reg <= '0;
      raddr3_reg <= '0;
      q_rise_reg <= '0;
      q_fall_reg <= '0;
      q_oe_reg <= RST_OE;
    end
    else
    begin
      last_op_reg <= last_op_next;
      wr1_reg <= wr1_next;
      wr2_reg <= wr2_next;
      waddr1_reg <= waddr1_next;
      waddr2_reg <= waddr2_next;
      rd1_reg <= rd1_next;
      rd2_reg <= rd2_next;
      rd3_reg <= rd3_next;
      raddr1_reg <= raddr1_next;
      raddr2_reg <= raddr2_next;
      raddr3_reg <= raddr3_next;
      q_rise_reg <= q_rise_next;
      q_fall_reg <= q_fall_next;
      q_oe_reg <= q_oe_next;
    end
  end

  // Array write enables for the word pair of this edge.
  logic wr_pair;
  logic [ADDR_W-1:0] wr_addr;
  int wr_word;

  always_comb
  begin
    wr_pair = PORT.run && (wr1_reg || wr2_reg);
    wr_addr = wr1_reg ? waddr1_reg : waddr2_reg;
    wr_word = wr1_reg ? 0 : 2;
  end

  // The array has no reset; its contents are undefined at power up.
  always_ff @(posedge CLK)
  begin
    if (wr_pair)
    begin
      for (int l = 0; l < LANES; l++)
      begin
        if (!PORT.byte_lane_write_select_n_rise[l])
        begin
          mem[wr_addr][wr_word][l*LANE_W +: LANE_W] <=
            PORT.d_rise[l*LANE_W +: LANE_W];
        end
        if (!PORT.byte_lane_write_select_n_fall[l])
        begin
          mem[wr_addr][wr_word+1][l*LANE_W +: LANE_W] <=
            PORT.d_fall[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  assign PORT.q_rise = q_rise_reg;
  assign PORT.q_fall = q_fall_reg;
  assign PORT.q_oe = q_oe_reg;

endmodule : burst4_sram_device

// [testbench/burst4_port_monitor.sv]
/*
  Concurrent checks on the link between the controller and device ends.
  Assumes one clock domain and that run low stands for stopped clocks.
*/
`timescale 1ns/1ps
module burst4_port_monitor #(
  parameter int DATA_W = 18,
  parameter int ADDR_W = 8,
  parameter int LANES = 2
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Link signals
  input wire logic run,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] d_rise,
  input wire logic [DATA_W-1:0] d_fall,
  input wire logic [LANES-1:0] byte_lane_write_select_n_rise,
  input wire logic [LANES-1:0] byte_lane_write_select_n_fall,
  input wire logic [DATA_W-1:0] q_rise,
  input wire logic [DATA_W-1:0] q_fall,
  input wire logic q_oe
);
  logic rd_start;
  logic wr_start;
  logic lanes_on;
  logic [3:0] rd_hist_reg;
  logic [3:0] rd_hist_next;
  logic [1:0] wr_hist_reg;
  logic [1:0] wr_hist_next;

  assign rd_start = run && !read_port_select_n;
  assign wr_start = run && !write_port_select_n;
  assign lanes_on = (byte_lane_write_select_n_rise != '1) ||
    (byte_lane_write_select_n_fall != '1);

  // History only advances on running edges, as the device freezes.
  always_comb
  begin
    rd_hist_next = rd_hist_reg;
    wr_hist_next = wr_hist_reg;
    if (run)
    begin
      rd_hist_next = {rd_hist_reg[2:0], rd_start};
      wr_hist_next = {wr_hist_reg[0], wr_start};
    end
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rd_hist_reg <= 4'h0;
      wr_hist_reg <= 2'h0;
    end
    else
    begin
      rd_hist_reg <= rd_hist_next;
      wr_hist_reg <= wr_hist_next;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  property p_read_window;
    rd_start |-> ##3 q_oe ##1 q_oe;
  endproperty
  a_read_window: assert property (p_read_window)
    else $error("read words not driven two cycles after latch");

  property p_oe_cause;
    q_oe |-> (rd_hist_reg[2] || rd_hist_reg[3]);
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("read bus driven outside a read window");

  property p_lane_window;
    lanes_on |-> (wr_hist_reg != 2'h0);
  endproperty
  a_lane_window: assert property (p_lane_window)
    else $error("lane enables outside write data cycles");

  property p_read_gap;
    !read_port_select_n |=> read_port_select_n;
  endproperty
  a_read_gap: assert property (p_read_gap)
    else $error("reads started on consecutive edges");

  property p_write_gap;
    !write_port_select_n |=> write_port_select_n;
  endproperty
  a_write_gap: assert property (p_write_gap)
    else $error("writes started on consecutive edges");

  property p_stop_hold;
    !run |=> $stable(q_rise) && $stable(q_fall) && $stable(q_oe);
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("outputs moved while clocks stopped");

  property p_write_run;
    wr_start |=> run [*2];
  endproperty
  a_write_run: assert property (p_write_run)
    else $error("clocks stopped during write data");

  property p_select_run;
    (!read_port_select_n || !write_port_select_n) |-> run;
  endproperty
  a_select_run: assert property (p_select_run)
    else $error("select asserted with clocks stopped");

  c_read: cover property (rd_start);
  c_write: cover property (wr_start);
  c_masked: cover property (lanes_on && byte_lane_write_select_n_rise != 0);
  c_stop: cover property (!run ##1 run);
endmodule : burst4_port_monitor

// [testbench/test_burst4_ddr_sram_port.sv]
/*
  Self-checking bench: controller and device joined by one link, driven
  through the command and response ports. Assumes an 18-bit link.
*/
`timescale 1ns/1ps
module test_burst4_ddr_sram_port;
  import burst4_pkg::*;
  localparam int DW = 18;
  localparam int AW = 8;
  localparam int LN = DW / LANE_W;
  localparam int BW = WORDS * DW;
  logic CLK;
  logic RESETN;
  logic CMD_VALID;
  logic CMD_READY;
  logic CMD_WRITE;
  logic RSP_VALID;
  logic RSP_READY;
  logic [AW-1:0] CMD_ADDR;
  logic [BW-1:0] CMD_WDATA;
  logic [BW-1:0] RSP_DATA;
  logic [WORDS*LN-1:0] CMD_LANE_N;
  logic [BW-1:0] ref_mem [0:255];
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;

  sram_port_if #(.DATA_W(DW), .ADDR_W(AW)) port_link ();

  burst4_sram_device #(.DATA_W(DW), .ADDR_W(AW)) i_burst4_sram_device (
    .CLK(CLK), .RESETN(RESETN), .PORT(port_link.dev));

  burst4_sram_controller #(.DATA_W(DW), .ADDR_W(AW))
    i_burst4_sram_controller (
    .CLK(CLK), .RESETN(RESETN), .CMD_VALID(CMD_VALID),
    .CMD_READY(CMD_READY), .CMD_WRITE(CMD_WRITE), .CMD_ADDR(CMD_ADDR),
    .CMD_WDATA(CMD_WDATA), .CMD_LANE_N(CMD_LANE_N),
    .RSP_VALID(RSP_VALID), .RSP_READY(RSP_READY), .RSP_DATA(RSP_DATA),
    .PORT(port_link.ctl));

  burst4_port_monitor #(.DATA_W(DW), .ADDR_W(AW), .LANES(LN))
    i_burst4_port_monitor (
    .CLK(CLK), .RESETN(RESETN), .run(port_link.run),
    .read_port_select_n(port_link.read_port_select_n),
    .write_port_select_n(port_link.write_port_select_n),
    .addr(port_link.addr), .d_rise(port_link.d_rise),
    .d_fall(port_link.d_fall),
    .byte_lane_write_select_n_rise(port_link.byte_lane_write_select_n_rise),
    .byte_lane_write_select_n_fall(port_link.byte_lane_write_select_n_fall),
    .q_rise(port_link.q_rise), .q_fall(port_link.q_fall),
    .q_oe(port_link.q_oe));

  initial
  begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  task automatic test_done();
    $display("checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  // A hung handshake ends the run here instead of spinning forever.
  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      err_total++;
      test_done();
    end
  end

  task automatic cmp_burst(input logic [BW-1:0] got, input logic [BW-1:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: burst %h, wanted %h", $time, got, exp);
    end
  endtask : cmp_burst

  task automatic cmp_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask : cmp_bit

  // The model applies only lanes whose enable is low in its own word.
  task automatic send(input logic wr, input logic [AW-1:0] a,
    input logic [BW-1:0] d, input logic [WORDS*LN-1:0] ln);
    int n;
    @(posedge CLK);
    CMD_VALID <= 1'b1;
    CMD_WRITE <= wr;
    CMD_ADDR <= a;
    CMD_WDATA <= d;
    CMD_LANE_N <= ln;
    n = 0;
    do
    begin
      @(posedge CLK);
      n++;
    end
    while (CMD_READY !== 1'b1 && n < 50);
    CMD_VALID <= 1'b0;
    cmp_bit(CMD_READY, 1'b1);
    for (int j = 0; j < WORDS * LN; j++)
      if (wr && !ln[j])
        ref_mem[a][j*LANE_W +: LANE_W] = d[j*LANE_W +: LANE_W];
  endtask : send

  task automatic recv(input logic [AW-1:0] a);
    int n;
    @(posedge CLK);
    RSP_READY <= 1'b1;
    n = 0;
    do
    begin
      @(posedge CLK);
      n++;
    end
    while (RSP_VALID !== 1'b1 && n < 50);
    RSP_READY <= 1'b0;
    cmp_bit(RSP_VALID, 1'b1);
    cmp_burst(RSP_DATA, ref_mem[a]);
  endtask : recv

  task automatic t_reset();
    repeat (2) @(posedge CLK);
    cmp_bit(port_link.q_oe, 1'b0);
    cmp_bit(CMD_READY, 1'b1);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_full();
    send(1'b1, 8'h10, {18'h3c00d, 18'h2b00c, 18'h1a00b, 18'h0900a},
      8'h00);
    send(1'b0, 8'h10, 72'h0, 8'hff);
    recv(8'h10);
    $display("t_full done");
  endtask : t_full

  task automatic t_lanes();
    send(1'b1, 8'h20, {18'h11111, 18'h22222, 18'h33333, 18'h04444},
      8'h00);
    // Word 0 both lanes, word 1 lower, word 2 upper, word 3 none.
    send(1'b1, 8'h20, {18'h2aaaa, 18'h35555, 18'h0f0f0, 18'h1e1e1},
      8'hd8);
    send(1'b0, 8'h20, 72'h0, 8'hff);
    recv(8'h20);
    $display("t_lanes done");
  endtask : t_lanes

  task automatic t_fwd();
    send(1'b1, 8'h30, {18'h01234, 18'h05678, 18'h09abc, 18'h0def0},
      8'h00);
    send(1'b0, 8'h30, 72'h0, 8'hff);
    recv(8'h30);
    $display("t_fwd done");
  endtask : t_fwd

  // Two reads held in the buffer must stop further commands.
  task automatic t_stall();
    send(1'b0, 8'h10, 72'h0, 8'hff);
    send(1'b0, 8'h20, 72'h0, 8'hff);
    repeat (12) @(posedge CLK);
    cmp_bit(CMD_READY, 1'b0);
    recv(8'h10);
    recv(8'h20);
    $display("t_stall done");
  endtask : t_stall

  initial
  begin
    RESETN = 1'b0;
    CMD_VALID = 1'b0;
    CMD_WRITE = 1'b0;
    CMD_ADDR = '0;
    CMD_WDATA = '0;
    CMD_LANE_N = '1;
    RSP_READY = 1'b0;
    repeat (16) @(posedge CLK);
    RESETN <= 1'b1;
    t_reset();
    t_full();
    t_lanes();
    t_fwd();
    t_stall();
    test_done();
  end
endmodule : test_burst4_ddr_sram_port
